// *** core/sar_adc_conversion_sequencer.v ***
`include "sar_adc_conversion_sequencer_defs.vh"

// ****************************************
// conversion sequencer top
// ****************************************
module sar_adc_conversion_sequencer #(
  parameter BYTE_WIDE    = 0,
  parameter WIDTH        = `RESULT_BITS,
  parameter CONV_MAX_CYC = `CONV_MAX_CYC,
  parameter STEP_DIV     = `STEP_DIV
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             arst_n,
  // host strobe pins
  input  wire             cs_n,
  input  wire             read_convert_sel,
  input  wire             upper_byte_select,
  // analog front end
  input  wire             comp_high,
  output reg              track_hold_q,
  output reg              ref_power_on_q,
  output wire [WIDTH-1:0] dac_code,
  // host status and data
  output reg              eoc_n_q,
  output reg  [WIDTH-1:0] data_out_bit_low_or_high,
  output reg  [WIDTH-1:0] data_oe
);

  // ****************************************
  // states
  // ****************************************
  localparam [2:0] ST_LOWPWR = 3'h0;
  localparam [2:0] ST_ACQ    = 3'h1;
  localparam [2:0] ST_CONV   = 3'h2;
  localparam [2:0] ST_DONE   = 3'h3;
  localparam [2:0] ST_READ   = 3'h4;

  reg  [2:0]             state_q;
  reg  [2:0]             state_d;
  reg  [2:0]             cs_sync_q;
  reg  [2:0]             rc_sync_q;
  reg  [2:0]             ub_sync_q;
  reg                    cs_q;
  reg                    rc_q;
  reg                    ub_q;
  reg                    cs_prev_q;
  reg                    shutdown_sel_q;
  reg  [`CNT_BITS-1:0]   conv_cnt_q;
  wire                   cs_fall;
  wire                   cs_rise;
  wire                   sar_start;
  wire                   sar_stop;
  wire                   sar_done;
  wire                   sar_busy;
  wire [WIDTH-1:0]       sar_result;
  wire [WIDTH-1:0]       byte_view;
  wire [WIDTH-1:0]       oe_mask;

  // ****************************************
  // pin synchronisers
  // ****************************************

  // three stages, change counted when stage two and three agree
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_sync_q <= 3'h7;
      rc_sync_q <= 3'h0;
      ub_sync_q <= 3'h0;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], cs_n};
      rc_sync_q <= {rc_sync_q[1:0], read_convert_sel};
      ub_sync_q <= {ub_sync_q[1:0], upper_byte_select};
    end
  end

  // filtered pin levels
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_q      <= 1'b1;
      rc_q      <= 1'b0;
      ub_q      <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      if (cs_sync_q[1] == cs_sync_q[2]) begin
        cs_q <= cs_sync_q[2];
      end
      if (rc_sync_q[1] == rc_sync_q[2]) begin
        rc_q <= rc_sync_q[2];
      end
      if (ub_sync_q[1] == ub_sync_q[2]) begin
        ub_q <= ub_sync_q[2];
      end
      cs_prev_q <= cs_q;
    end
  end

  assign cs_fall = cs_prev_q && !cs_q;
  assign cs_rise = !cs_prev_q && cs_q;

  // ****************************************
  // strobe sequence
  // ****************************************

  // first fall acquires, second converts, third reads
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_LOWPWR: begin
        if (cs_fall && !rc_q) begin
          state_d = ST_ACQ;                // select high ignored here
        end
      end
      ST_ACQ: begin
        if (cs_fall) begin
          state_d = ST_CONV;               // acquisition ends
        end
      end
      ST_CONV: begin
        if (sar_done) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (cs_fall && rc_q) begin
          state_d = ST_READ;               // result onto bus
        end else if (cs_fall) begin
          state_d = ST_ACQ;
        end
      end
      ST_READ: begin
        if (cs_rise) begin
          state_d = ST_LOWPWR;
        end
      end
      default: begin
        state_d = ST_LOWPWR;
      end
    endcase
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_LOWPWR;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // track-and-hold and power modes
  // ****************************************

  // hold from second fall until conversion done
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      track_hold_q <= 1'b0;
    end else if (state_q == ST_ACQ && cs_fall) begin
      track_hold_q <= 1'b1;                // sampling switch opens
    end else if (sar_done) begin
      track_hold_q <= 1'b0;
    end
  end

  // select level caught at hold chooses low-power mode
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shutdown_sel_q <= 1'b1;
    end else if (state_q == ST_ACQ && cs_fall) begin
      shutdown_sel_q <= rc_q;              // high means shutdown
    end
  end

  // reference on for acquisition, off after shutdown conversion
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_power_on_q <= 1'b0;
    end else if (state_d == ST_ACQ) begin
      ref_power_on_q <= 1'b1;
    end else if (sar_done && shutdown_sel_q) begin
      ref_power_on_q <= 1'b0;              // automatic shutdown
    end
  end

  // ****************************************
  // conversion timing
  // ****************************************

  assign sar_start = (state_q == ST_ACQ) && cs_fall;

  // cycles spent in hold, capped at the conversion limit
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_cnt_q <= 8'h00;
    end else if (sar_start) begin
      conv_cnt_q <= 8'h01;
    end else if (state_q == ST_CONV && sar_busy) begin
      conv_cnt_q <= conv_cnt_q + 8'h01;
    end
  end

  // stop one cycle early so the flag falls by the limit
  assign sar_stop = (conv_cnt_q >= (CONV_MAX_CYC[`CNT_BITS-1:0] - 8'h01));

  successive_approximation #(
    .WIDTH    (WIDTH),
    .STEP_DIV (STEP_DIV)
  ) u_sar (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .start      (sar_start),
    .force_stop (sar_stop),
    .comp_high  (comp_high),
    .dac_code_q (dac_code),
    .result_q   (sar_result),
    .done_q     (sar_done),
    .busy_q     (sar_busy)
  );

  // ****************************************
  // end-of-conversion flag
  // ****************************************

  // falls when result valid, rises when next acquisition starts
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      eoc_n_q <= 1'b1;
    end else if (sar_done) begin
      eoc_n_q <= 1'b0;                     // result ready
    end else if (state_d == ST_ACQ && state_q != ST_ACQ) begin
      eoc_n_q <= 1'b1;
    end
  end

  // ****************************************
  // three-state data port
  // ****************************************

  // byte variant puts low or high byte on the low pins
  assign byte_view = ub_q ? {{(WIDTH-`BYTE_BITS){1'b0}}, sar_result[WIDTH-1:`BYTE_BITS]}
                          : {{(WIDTH-`BYTE_BITS){1'b0}}, sar_result[`BYTE_BITS-1:0]};
  assign oe_mask   = (BYTE_WIDE != 0) ? {{(WIDTH-`BYTE_BITS){1'b0}}, {`BYTE_BITS{1'b1}}}
                                      : {WIDTH{1'b1}};

  // drive only in read with strobe low, else released
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out_bit_low_or_high <= `RESULT_RST;
      data_oe                  <= `RESULT_RST;
    end else if (state_d == ST_READ && !cs_q) begin
      data_out_bit_low_or_high <= (BYTE_WIDE != 0) ? byte_view : sar_result;
      data_oe                  <= oe_mask;
    end else begin
      data_out_bit_low_or_high <= `RESULT_RST;
      data_oe                  <= `RESULT_RST;  // high impedance
    end
  end

endmodule // sar_adc_conversion_sequencer

// *** core/sar_adc_conversion_sequencer_defs.vh ***
// Functional notes
// - second strobe fall ends acquisition, opens sampling switch, holds the sample
// - conversion done and end flag low within 4.7us of entering hold
// - step timing comes from an internal divider, no host clock needed
// - after each conversion enter standby or shutdown as selected at hold
// - data pins three-state; byte variant muxes low or high byte per select
// - 16-bit unsigned result by successive approximation behind track-and-hold
// - select low at hold gives standby, high gives shutdown of reference
// - first fall with select low acquires, second converts, third with high reads
// - falling end-of-conversion flag marks result valid and ready
// - data pins high impedance in acquisition, conversion and whenever strobe high
`ifndef SAR_ADC_CONVERSION_SEQUENCER_DEFS_VH
`define SAR_ADC_CONVERSION_SEQUENCER_DEFS_VH

// ****************************************
// widths and reset values
// ****************************************
`define RESULT_BITS      16
`define RESULT_RST       16'h0000
`define CODE_MSB_ONLY    16'h8000
`define BIT_IDX_BITS     4
`define BIT_IDX_MSB      4'hF
`define BIT_IDX_LSB      4'h0
`define BYTE_BITS        8

// ****************************************
// timing
// ****************************************
`define CLK_FREQ_MHZ     10
`define CONV_TIME_NS     4700
`define CONV_MAX_CYC     ((`CONV_TIME_NS * `CLK_FREQ_MHZ) / 1000)
`define ACQ_MIN_NS       1100
`define ACQ_MIN_CYC      ((`ACQ_MIN_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define STEP_DIV         2
`define CNT_BITS         8

`endif

// *** core/successive_approximation.v ***
`include "sar_adc_conversion_sequencer_defs.vh"

// ****************************************
// successive approximation step engine
// ****************************************
module successive_approximation #(
  parameter WIDTH    = `RESULT_BITS,
  parameter STEP_DIV = `STEP_DIV
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             arst_n,
  // control
  input  wire             start,
  input  wire             force_stop,
  input  wire             comp_high,
  // results
  output reg  [WIDTH-1:0] dac_code_q,
  output reg  [WIDTH-1:0] result_q,
  output reg              done_q,
  output reg              busy_q
);

  reg [`BIT_IDX_BITS-1:0] bit_idx_q;
  reg [`CNT_BITS-1:0]     div_q;
  wire                    step_tick;

  // one-hot trial weight for a bit position
  function [WIDTH-1:0] trial_bit;
    input [`BIT_IDX_BITS-1:0] idx;
    begin
      trial_bit = {{(WIDTH-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  // internal conversion clock from divider
  assign step_tick = busy_q && (div_q == (STEP_DIV[`CNT_BITS-1:0] - 8'h01));

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 8'h00;
    end else if (!busy_q || step_tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // binary search, msb first, keep bit if input above trial
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_code_q <= `RESULT_RST;
      result_q   <= `RESULT_RST;
      bit_idx_q  <= `BIT_IDX_MSB;
      done_q     <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        dac_code_q <= trial_bit(`BIT_IDX_MSB);
        bit_idx_q  <= `BIT_IDX_MSB;
        busy_q     <= 1'b1;
      end else if (busy_q && force_stop) begin
        result_q <= dac_code_q;            // limit reached, keep best code
        done_q   <= 1'b1;
        busy_q   <= 1'b0;
      end else if (step_tick) begin
        if (bit_idx_q == `BIT_IDX_LSB) begin
          result_q <= comp_high ? dac_code_q : (dac_code_q & ~trial_bit(bit_idx_q));
          done_q   <= 1'b1;
          busy_q   <= 1'b0;
        end else begin
          dac_code_q <= (comp_high ? dac_code_q : (dac_code_q & ~trial_bit(bit_idx_q)))
                        | trial_bit(bit_idx_q - 4'h1);
          bit_idx_q  <= bit_idx_q - 4'h1;
        end
      end
    end
  end

endmodule // successive_approximation

// *** test/host_cpu.sv ***
module host_cpu (
  // clock and status
  input  logic core_clk,
  input  logic eoc_n_q,
  // strobe pins
  output logic cs_n,
  output logic read_convert_sel,
  output logic upper_byte_select
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs_n = 1'b1;
    read_convert_sel = 1'b0;
    upper_byte_select = 1'b0;
  end

  // select set ahead, strobe low long enough to count
  task automatic fall(input logic sel);
    @(posedge core_clk) read_convert_sel <= sel;
    repeat (5) @(posedge core_clk);
    cs_n <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  // 12+ cycles between falls covers acquisition
  task automatic rise();
    cs_n <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic sel_byte(input logic b);
    upper_byte_select <= b;
    repeat (6) @(posedge core_clk);
  endtask

  // bounded wait for end flag before reading
  task automatic wait_eoc(output int n);
    n = 0;
    while (eoc_n_q !== 1'b0 && n < 80) begin
      @(posedge core_clk);
      n++;
    end
  endtask
endmodule // host_cpu

// *** test/sar_adc_conversion_sequencer_props.sv ***
module sar_adc_conversion_sequencer_props #(
  parameter WIDTH        = 16,
  parameter CONV_MAX_CYC = 47
) (
  input wire logic             core_clk,
  input wire logic             arst_n,
  input wire logic             cs_n,
  input wire logic             read_convert_sel,
  input wire logic             track_hold_q,
  input wire logic             ref_power_on_q,
  input wire logic [WIDTH-1:0] dac_code,
  input wire logic             eoc_n_q,
  input wire logic [WIDTH-1:0] data_out_bit_low_or_high,
  input wire logic [WIDTH-1:0] data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV_LAST = CONV_MAX_CYC - 1;
  logic shut_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_hold_start;
    $rose(track_hold_q);
  endsequence
  sequence s_conv_end;
    $fell(eoc_n_q);
  endsequence

  // power mode picked at hold entry
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n) shut_q <= 1'b0;
    else if ($rose(track_hold_q)) shut_q <= read_convert_sel;

  AST_CONV_BOUND: assert property (s_hold_start |-> ##[1:CONV_LAST] s_conv_end)
    else $error("conversion too long");
  AST_FIRST_TRIAL: assert property (s_hold_start |-> dac_code == 16'h8000)
    else $error("first trial code wrong");
  AST_HOLD_RELEASE: assert property (s_conv_end |-> !track_hold_q)
    else $error("hold kept after end");
  AST_EOC_HOLDS: assert property (s_conv_end |=> !eoc_n_q [*3])
    else $error("end flag dropped early");
  AST_POWER_MODE: assert property (s_conv_end |-> ref_power_on_q == !shut_q)
    else $error("wrong low power mode");
  AST_REF_IN_CONV: assert property (track_hold_q |-> ref_power_on_q && eoc_n_q)
    else $error("converting unpowered");
  AST_QUIET_CONV: assert property (track_hold_q || eoc_n_q |-> data_oe == '0)
    else $error("bus driven in conversion");
  AST_UNDRIVEN_ZERO: assert property (data_oe == '0 |-> data_out_bit_low_or_high == '0)
    else $error("data without enable");
  AST_CS_HIGH_QUIET: assert property (cs_n [*7] |-> data_oe == '0)
    else $error("bus driven with strobe high");
endmodule // sar_adc_conversion_sequencer_props

bind sar_adc_conversion_sequencer sar_adc_conversion_sequencer_props #(
  .WIDTH(WIDTH), .CONV_MAX_CYC(CONV_MAX_CYC)) props_i (.core_clk, .arst_n, .cs_n,
  .read_convert_sel, .track_hold_q, .ref_power_on_q, .dac_code, .eoc_n_q,
  .data_out_bit_low_or_high, .data_oe);

// *** test/sar_adc_conversion_sequencer_test.sv ***
module sar_adc_conversion_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk;
  logic        arst_n;
  logic        cs_n;
  logic        read_convert_sel;
  logic        upper_byte_select;
  logic        track_hold_q;
  logic        ref_power_on_q;
  logic        eoc_n_q;
  logic [15:0] dac_code;
  logic [15:0] data_out_bit_low_or_high;
  logic [15:0] data_oe;
  logic [15:0] data_b;
  logic [15:0] oe_b;
  logic        track_hold_b;
  logic        ref_b;
  logic        eoc_b;
  logic [15:0] dac_b;
  logic [16:0] analog_input;
  int          errors;
  int          tests_run;

  // input sits mid-code so compare direction cannot matter
  wire comp_high = analog_input > {dac_code, 1'b0};

  sar_adc_conversion_sequencer sar_adc_conversion_sequencer_i (.core_clk, .arst_n,
    .cs_n, .read_convert_sel, .upper_byte_select, .comp_high, .track_hold_q,
    .ref_power_on_q, .dac_code, .eoc_n_q, .data_out_bit_low_or_high, .data_oe);
  sar_adc_conversion_sequencer #(.BYTE_WIDE(1)) sar_adc_conversion_sequencer_b_i (
    .core_clk, .arst_n, .cs_n, .read_convert_sel, .upper_byte_select, .comp_high,
    .track_hold_q(track_hold_b), .ref_power_on_q(ref_b), .dac_code(dac_b), .eoc_n_q(eoc_b),
    .data_out_bit_low_or_high(data_b), .data_oe(oe_b));
  host_cpu host_cpu_i (.core_clk, .eoc_n_q, .cs_n, .read_convert_sel, .upper_byte_select);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // full acquire, hold, convert, read cycle
  task automatic t_convert(input logic [15:0] code, input logic sel);
    int n;
    analog_input = {code, 1'b1};
    host_cpu_i.fall(1'b0);
    check("ref_on", 16'h0001, ref_power_on_q);
    host_cpu_i.rise();
    host_cpu_i.fall(sel);
    check("hold", 16'h0001, track_hold_q);
    check("hold_b", 16'h0001, track_hold_b);
    check("first_trial_b", 16'h8000, dac_b);
    host_cpu_i.wait_eoc(n);
    // flag due 47 cycles after counting starts, which lies 5 edges after the pin fall
    check("conv_time", 16'h0001, n <= 42);
    check("hold_off", 16'h0000, track_hold_q);
    check("ref_mode", !sel, ref_power_on_q);
    check("ref_mode_b", !sel, ref_b);
    check("eoc_b", 16'h0000, eoc_b);
    host_cpu_i.rise();
    host_cpu_i.fall(1'b1);
    check("data", code, data_out_bit_low_or_high);
    check("oe", 16'hFFFF, data_oe);
    check("oe_byte", 16'h00FF, oe_b);
    check("low_byte", code[7:0], data_b[7:0]);
    host_cpu_i.sel_byte(1'b1);
    check("high_byte", code[15:8], data_b[7:0]);
    host_cpu_i.sel_byte(1'b0);
    host_cpu_i.rise();
    check("oe_off", 16'h0000, data_oe);
  endtask

  // fall with select high from shutdown is ignored
  task automatic t_refused();
    host_cpu_i.fall(1'b1);
    check("ref_idle", 16'h0000, ref_power_on_q);
    check("oe_idle", 16'h0000, data_oe);
    host_cpu_i.rise();
  endtask

  // early read fall while converting leaves the bus off
  task automatic t_busy();
    int n;
    host_cpu_i.fall(1'b0);
    host_cpu_i.rise();
    host_cpu_i.fall(1'b0);
    host_cpu_i.rise();
    host_cpu_i.fall(1'b1);
    check("oe_busy", 16'h0000, data_oe);
    host_cpu_i.rise();
    host_cpu_i.wait_eoc(n);
    check("eoc_busy", 16'h0000, eoc_n_q);
  endtask

  initial begin
    arst_n = 1'b0;
    analog_input = '0;
    errors = 0;
    tests_run = 0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("eoc_rst", 16'h0001, eoc_n_q);
    t_refused();
    t_convert(16'hA5C3, 1'b0);
    t_convert(16'hFFFF, 1'b1);
    t_convert(16'h0000, 1'b0);
    t_busy();
    t_convert(16'h5A3C, 1'b1);
    wrap_up();
  end

  // watchdog
  initial begin
    #300us;
    errors++;
    wrap_up();
  end
endmodule // sar_adc_conversion_sequencer_test
